/* File: core/mmi2c_pkg.sv */
/*
 * package: register map, field positions, reset values and state types
 * for the two-instance multi-master two-wire interface.
 * assumes an apb master on clk_sys and open-drain scl/sda pins.
 */
package mmi2c_pkg;
  localparam int          N_INST        = 2;
  localparam logic [4:0]  OFS_ROUTE     = 5'h00;
  localparam logic [4:0]  OFS_SHIFT     = 5'h04;
  localparam logic [4:0]  OFS_TXBUF     = 5'h08;
  localparam logic [4:0]  OFS_ADDR      = 5'h0c;
  localparam logic [4:0]  OFS_CLK       = 5'h10;
  localparam logic [4:0]  OFS_CTL       = 5'h14;
  localparam logic [4:0]  OFS_STAT      = 5'h18;
  localparam int          INST_SEL_BIT  = 5;
  localparam int          ROUTE_ALT     = 0;
  localparam int          ROUTE_VALID   = 2;
  localparam int          CLK_FAST      = 5;
  localparam int          CLK_ACKLVL    = 6;
  localparam int          CLK_ACKCLK    = 7;
  localparam int          CTL_ESO       = 3;
  localparam int          CTL_ALS       = 4;
  localparam int          CTL_WIDE      = 5;
  localparam int          ST_LRB        = 0;
  localparam int          ST_AAS        = 2;
  localparam int          ST_AL         = 3;
  localparam int          ST_PIN        = 4;
  localparam int          ST_BB         = 5;
  localparam int          ST_TRX        = 6;
  localparam int          ST_MST        = 7;
  localparam logic [7:0]  RST_REG       = 8'h00;
  localparam logic [4:0]  VALID_DLY_CYC = 5'h14;
  localparam logic [7:0]  SCL_HALF_BASE = 8'h04;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_DATA = 3'b010,
    PH_ACK  = 3'b100
  } phase_t;

  typedef struct packed {
    logic [7:0] route;
    logic [7:0] shift;
    logic [7:0] sadr;
    logic [7:0] clkc;
    logic [7:0] ctl;
    logic       last_received_bit;
    logic       aas;
    logic       al;
    logic       pin;
    logic       bb;
    logic       trx;
    logic       master_select;
    logic [4:0] vcnt;
    logic       active;
    phase_t     ph;
    logic [3:0] bcnt;
    logic       addr_ph;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       scl_p;
    logic       sda_p;
    logic [7:0] div;
    logic       scl_gen;
    logic       scl_oe_n;
    logic       sda_oe_n;
  } inst_t;

  typedef struct packed {
    inst_t [N_INST-1:0] u;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               uart_alt;
  } state_t;
endpackage

/* File: core/multi_master_i2c_regs.sv */
/*
 * two independent multi-master two-wire interfaces behind one apb slave.
 * each instance holds route, shift, tx buffer, address, clock, control
 * and status registers; instance i sits at byte offset 0x20*i.
 * assumes scl/sda are open-drain wires pulled high outside, asynchronous
 * to clk_sys, and clk_sys is the bus clock.
 */
// Overview of operation
// - instance 0 route bit steers uart pins; valid bit overrides it.
// - valid bit 0 keeps an instance inactive, 1 connects it to pins.
// - instance becomes active 21 clocks after valid set; no access meanwhile.
// - shift register sends from bit 7, receives into bit 0, shifts left.
// - shift writes need use-enable; reads always allowed.
// - shift write clears bit counter; with enable and master starts scl.
// - tx buffer write loads shift in master, no scl; never readable.
// - address bits 7:1 compare; bit 0 ignored in 7-bit; stop clears it unless counter field is 7.
// - 10-bit mode compares first address byte with all eight bits.
// - clock bits 4:0 set scl rate, bit 5 picks high-speed mode.
// - clock bit 6 zero drives ack low, one leaves sda high.
// - address reception auto-acks on match when clock bit 6 is zero, stays high on mismatch.
// - clock bit 7 adds ack clock; transmitter releases sda, samples ack.
// - clock register write resets scl generator; not during transfers.
// - counter field sets byte length, zero means 8; start clears it.
// - use-enable low releases pins, pin=1, busy and lost cleared.
// - control bit 4 one selects free format, no address recognition.
// - control bit 5 picks 7-bit or full 8-bit address compare.
// - status bits 6, 7 writable, bit 4 can only be set by a write; others read-only.
// - last bit holds ack or final data bit; shift writes clear it.
// - two instances with own logic, working independently.
module multi_master_i2c_regs
  import mmi2c_pkg::*;
#(
  parameter int N = N_INST
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [N-1:0] scl_i,
  input  wire logic [N-1:0] sda_i,
  output logic      [N-1:0] scl_o,
  output logic      [N-1:0] scl_oe_n,
  output logic      [N-1:0] sda_o,
  output logic      [N-1:0] sda_oe_n,
  output logic      [N-1:0] if_active,
  output logic             uart_alt_route
);
  state_t q;
  state_t d;

  function automatic logic [7:0] reg_rd(input inst_t u, input logic [4:0] o);
    logic [7:0] r;
    r = 8'h00;
    case (o)
      OFS_ROUTE: r = u.route;
      OFS_SHIFT: r = u.shift;
      OFS_ADDR:  r = u.sadr;
      OFS_CLK:   r = u.clkc;
      OFS_CTL:   r = u.ctl;
      OFS_STAT:  r = {u.master_select, u.trx, u.bb, u.pin, u.al, u.aas, 1'b0, u.last_received_bit};
      default:   r = 8'h00;
    endcase
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[7:6] == 2'h0 && a[1:0] == 2'h0 && a[4:0] <= OFS_STAT;
  endfunction

  function automatic logic start_det(input inst_t u);
    return u.scl_s[1] && u.scl_p && u.sda_p && !u.sda_s[1];
  endfunction

  function automatic logic stop_det(input inst_t u);
    return u.scl_s[1] && u.scl_p && !u.sda_p && u.sda_s[1];
  endfunction

  function automatic logic [7:0] half_cyc(input logic [7:0] c);
    logic [7:0] h;
    h = 8'((c[4:0] + 5'h01) * SCL_HALF_BASE);
    return c[CLK_FAST] ? {1'b0, h[7:1]} : h;
  endfunction

  logic wr_go;
  logic rd_go;
  assign wr_go = psel && penable && q.pready && pwrite && !q.pslverr;
  assign rd_go = psel && penable && q.pready && !pwrite;

  always_comb begin
    logic       sel;
    logic       rise;
    logic       fall;
    logic       sda_in;
    logic       match;
    logic       drive_low;
    logic [3:0] nbits;
    d = q;
    sel = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    sda_in = 1'b0;
    match = 1'b0;
    drive_low = 1'b0;
    nbits = 4'h0;
    // apb setup phase latches answer, access phase completes
    if (psel && !penable) begin
      d.pready = 1'b1;
      d.pslverr = !mapped(paddr);
      d.prdata = {24'h00_0000, reg_rd(q.u[paddr[INST_SEL_BIT]], paddr[4:0])};
    end else begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
    end
    for (int i = 0; i < N; i++) begin
      sel = wr_go && (paddr[INST_SEL_BIT] == 1'(i));
      d.u[i].scl_s = {q.u[i].scl_s[0], scl_i[i]};
      d.u[i].sda_s = {q.u[i].sda_s[0], sda_i[i]};
      d.u[i].scl_p = q.u[i].scl_s[1];
      d.u[i].sda_p = q.u[i].sda_s[1];
      rise = q.u[i].scl_s[1] && !q.u[i].scl_p;
      fall = !q.u[i].scl_s[1] && q.u[i].scl_p;
      sda_in = q.u[i].sda_s[1];
      // activation delay after valid bit
      if (!q.u[i].route[ROUTE_VALID]) begin
        d.u[i].vcnt = 5'h00;
        d.u[i].active = 1'b0;
      end else if (q.u[i].vcnt != VALID_DLY_CYC) begin
        d.u[i].vcnt = q.u[i].vcnt + 5'h01;
      end else begin
        d.u[i].active = 1'b1;
      end
      // software writes
      if (sel) begin
        case (paddr[4:0])
          OFS_ROUTE: d.u[i].route = (i == 0) ? pwdata[7:0] : (pwdata[7:0] & 8'h04);
          OFS_SHIFT: begin
            if (q.u[i].ctl[CTL_ESO]) begin
              d.u[i].shift = pwdata[7:0];
              d.u[i].bcnt = 4'h0;
              d.u[i].last_received_bit = 1'b0;
              d.u[i].aas = 1'b0;
              d.u[i].pin = 1'b1;
              d.u[i].ph = PH_DATA;
              d.u[i].div = 8'h00;
              d.u[i].scl_gen = q.u[i].scl_gen && !q.u[i].master_select;
            end
          end
          OFS_TXBUF: begin
            if (q.u[i].ctl[CTL_ESO] && q.u[i].master_select) begin
              d.u[i].shift = pwdata[7:0];
              d.u[i].last_received_bit = 1'b0;
              d.u[i].aas = 1'b0;
            end
          end
          OFS_ADDR: d.u[i].sadr = pwdata[7:0];
          OFS_CLK: begin
            d.u[i].clkc = pwdata[7:0];
            d.u[i].div = 8'h00;
            d.u[i].scl_gen = 1'b1;
          end
          OFS_CTL: d.u[i].ctl = {2'b00, pwdata[5:0]};
          OFS_STAT: begin
            d.u[i].master_select = pwdata[ST_MST];
            d.u[i].trx = pwdata[ST_TRX];
            d.u[i].pin = pwdata[ST_PIN] | q.u[i].pin;
          end
          default: d.u[i].route = q.u[i].route;
        endcase
      end
      // byte length: counter field of zero means eight bits
      nbits = (q.u[i].ctl[2:0] == 3'h0 || q.u[i].addr_ph) ? 4'h8 :
              {1'b0, q.u[i].ctl[2:0]};
      // master clock generator
      if (q.u[i].master_select && q.u[i].ph != PH_IDLE && q.u[i].active) begin
        if (q.u[i].div >= half_cyc(q.u[i].clkc) - 8'h01) begin
          d.u[i].div = 8'h00;
          d.u[i].scl_gen = !q.u[i].scl_gen;
        end else begin
          d.u[i].div = q.u[i].div + 8'h01;
        end
      end
      // bus events; hardware sets win over software writes
      if (start_det(q.u[i])) begin
        d.u[i].bb = 1'b1;
        d.u[i].bcnt = 4'h0;
        d.u[i].ctl[2:0] = 3'h0;
        d.u[i].addr_ph = 1'b1;
        d.u[i].ph = PH_DATA;
        if (!q.u[i].master_select)
          d.u[i].trx = 1'b0;
      end else if (stop_det(q.u[i]) && q.u[i].ctl[2:0] != 3'h7) begin
        d.u[i].bb = 1'b0;
        d.u[i].trx = 1'b0;
        d.u[i].master_select = 1'b0;
        d.u[i].aas = 1'b0;
        d.u[i].sadr[0] = 1'b0;
        d.u[i].ph = PH_IDLE;
        d.u[i].addr_ph = 1'b0;
      end else if (rise && q.u[i].ph == PH_DATA) begin
        d.u[i].shift = {q.u[i].shift[6:0], sda_in};
        d.u[i].bcnt = q.u[i].bcnt + 4'h1;
        if (q.u[i].trx && q.u[i].master_select && q.u[i].shift[7] && !sda_in) begin
          d.u[i].al = 1'b1;
          d.u[i].trx = 1'b0;
        end
        if (q.u[i].bcnt + 4'h1 == nbits) begin
          if (q.u[i].clkc[CLK_ACKCLK]) begin
            d.u[i].ph = PH_ACK;
          end else begin
            d.u[i].ph = PH_IDLE;
            d.u[i].pin = 1'b0;
            d.u[i].last_received_bit = sda_in;
            d.u[i].scl_gen = 1'b1;
          end
          if (q.u[i].addr_ph && !q.u[i].ctl[CTL_ALS]) begin
            match = q.u[i].ctl[CTL_WIDE] ?
                    ({q.u[i].shift[6:0], sda_in} == q.u[i].sadr) :
                    (q.u[i].shift[6:0] == q.u[i].sadr[7:1]);
            match = match || ({q.u[i].shift[6:0], sda_in} == 8'h00);
            d.u[i].aas = match;
            if (match && !q.u[i].master_select && !q.u[i].ctl[CTL_WIDE])
              d.u[i].trx = sda_in;
          end
        end
      end else if (rise && q.u[i].ph == PH_ACK) begin
        d.u[i].last_received_bit = sda_in;
        d.u[i].ph = PH_IDLE;
        d.u[i].scl_gen = 1'b1;
        d.u[i].pin = 1'b0;
        d.u[i].addr_ph = 1'b0;
        if (!q.u[i].master_select && sda_in)
          d.u[i].trx = 1'b0;
      end
      // sda drive decision, changed only while scl is low
      if (fall || (q.u[i].ph == PH_IDLE && !q.u[i].scl_s[1])) begin
        if (q.u[i].ph == PH_ACK) begin
          if (q.u[i].addr_ph && !q.u[i].ctl[CTL_ALS]) begin
            drive_low = !q.u[i].clkc[CLK_ACKLVL] && q.u[i].aas;
          end else if (q.u[i].trx) begin
            drive_low = 1'b0;
          end else begin
            drive_low = !q.u[i].clkc[CLK_ACKLVL];
          end
        end else if (q.u[i].ph == PH_DATA && q.u[i].trx && !q.u[i].al) begin
          drive_low = !q.u[i].shift[7];
        end
        d.u[i].sda_oe_n = !drive_low;
      end
      d.u[i].scl_oe_n = !(!q.u[i].scl_gen || (!q.u[i].pin && q.u[i].bb));
      // inactive or disabled interface releases the wires
      if (!q.u[i].ctl[CTL_ESO]) begin
        d.u[i].pin = 1'b1;
        d.u[i].bb = 1'b0;
        d.u[i].al = 1'b0;
        d.u[i].ph = PH_IDLE;
        d.u[i].scl_gen = 1'b1;
      end
      if (!q.u[i].ctl[CTL_ESO] || !q.u[i].active) begin
        d.u[i].scl_oe_n = 1'b1;
        d.u[i].sda_oe_n = 1'b1;
      end
    end
    d.uart_alt = q.u[0].route[ROUTE_ALT] && !q.u[0].route[ROUTE_VALID];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      for (int i = 0; i < N_INST; i++) begin
        q.u[i].pin <= 1'b1;
        q.u[i].ph <= PH_IDLE;
        q.u[i].scl_gen <= 1'b1;
        q.u[i].scl_oe_n <= 1'b1;
        q.u[i].sda_oe_n <= 1'b1;
        q.u[i].scl_s <= 2'b11;
        q.u[i].sda_s <= 2'b11;
        q.u[i].scl_p <= 1'b1;
        q.u[i].sda_p <= 1'b1;
      end
    end else begin
      q <= d;
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      scl_oe_n[i] = q.u[i].scl_oe_n;
      sda_oe_n[i] = q.u[i].sda_oe_n;
      if_active[i] = q.u[i].active;
    end
  end
  assign scl_o = '0;
  assign sda_o = '0;
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign uart_alt_route = q.uart_alt;

  logic wr0;
  assign wr0 = wr_go && !paddr[INST_SEL_BIT];

  AST_ACTIVE_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(q.u[0].route[ROUTE_VALID]) |-> !q.u[0].active ##21
      (q.u[0].active || !q.u[0].route[ROUTE_VALID]))
    else $error("activation delay wrong");
  AST_SHIFT_BLOCKED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr0 && paddr[4:0] == OFS_SHIFT && !q.u[0].ctl[CTL_ESO] && q.u[0].ph == PH_IDLE
      |=> $stable(q.u[0].shift))
    else $error("shift written while disabled");
  AST_SHIFT_WR_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr0 && paddr[4:0] == OFS_SHIFT && q.u[0].ctl[CTL_ESO] && !start_det(q.u[0])
      |=> q.u[0].bcnt == 4'h0 && !q.u[0].last_received_bit && q.u[0].shift == $past(pwdata[7:0]))
    else $error("shift write did not reset counter");
  AST_TXBUF_NO_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    psel && !penable && !pwrite && paddr[4:0] == OFS_TXBUF |=> prdata == 32'h0000_0000)
    else $error("tx buffer readable");
  AST_ESO_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !q.u[0].ctl[CTL_ESO] |=> q.u[0].pin && !q.u[0].bb && !q.u[0].al
      && scl_oe_n[0] && sda_oe_n[0])
    else $error("disable did not release interface");
  AST_STOP_CLR_RBW: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stop_det(q.u[0]) && !start_det(q.u[0]) && q.u[0].ctl[2:0] != 3'h7 && !wr0
      |=> !q.u[0].sadr[0] && !q.u[0].bb)
    else $error("stop did not clear rw bit");
  AST_START_CNT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    start_det(q.u[0]) && q.u[0].ctl[CTL_ESO]
      |=> q.u[0].bcnt == 4'h0 && q.u[0].addr_ph && q.u[0].bb)
    else $error("start did not clear counter");
  AST_CLK_WR_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr0 && paddr[4:0] == OFS_CLK |=> q.u[0].div == 8'h00 && q.u[0].scl_gen)
    else $error("clock write did not reset generator");
  AST_UART_ROUTE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    q.u[0].route[ROUTE_VALID] |=> !uart_alt_route)
    else $error("valid bit did not override route");
  AST_INST1_ROUTE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_go && paddr[INST_SEL_BIT] && paddr[4:0] == OFS_ROUTE
      |=> !q.u[1].route[ROUTE_ALT])
    else $error("instance 1 kept route bit");
  AST_TXBUF_NO_SCL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr0 && paddr[4:0] == OFS_TXBUF && q.u[0].ctl[CTL_ESO] && q.u[0].ph == PH_IDLE
      |=> $stable(q.u[0].scl_gen))
    else $error("tx buffer write started scl");
  AST_TXBUF_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr0 && paddr[4:0] == OFS_TXBUF && q.u[0].ctl[CTL_ESO] && q.u[0].master_select
      && q.u[0].ph == PH_IDLE
      |=> !q.u[0].last_received_bit && q.u[0].shift == $past(pwdata[7:0]))
    else $error("tx buffer write did not load shift");
  AST_TXBUF_BLOCKED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr0 && paddr[4:0] == OFS_TXBUF && !(q.u[0].ctl[CTL_ESO] && q.u[0].master_select)
      && q.u[0].ph == PH_IDLE |=> $stable(q.u[0].shift))
    else $error("tx buffer written while blocked");
  AST_ADDR_ACK_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    q.u[0].ph == PH_ACK && q.u[0].addr_ph && !q.u[0].ctl[CTL_ALS]
      && !q.u[0].clkc[CLK_ACKLVL] && q.u[0].aas && !q.u[0].scl_s[1] && q.u[0].scl_p
      && q.u[0].ctl[CTL_ESO] && q.u[0].active |=> !sda_oe_n[0])
    else $error("matching address not acknowledged");
  AST_TX_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    q.u[0].ph == PH_ACK && q.u[0].trx && !q.u[0].addr_ph
      && !q.u[0].scl_s[1] && q.u[0].scl_p |=> sda_oe_n[0])
    else $error("transmitter held sda in ack clock");
  COV_ACK_PHASE: cover property (@(posedge clk_sys) disable iff (!rst_n)
    q.u[0].ph == PH_ACK && q.u[0].master_select);
  COV_ACTIVATE: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(q.u[0].active));
  COV_BYTE_DONE: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(q.u[0].pin));
  COV_ADDR_MATCH: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(q.u[0].aas));
endmodule

/* File: testbench/i2c_bus_partner.sv */
/*
 * partner: one open-drain two-wire bus with pull-ups, a master that sends
 * address frames and a slave that acknowledges in the ninth clock.
 * assumes the dut enables are active low and nobody else drives the wires.
 */
module i2c_bus_partner (
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  input  wire logic ack_en,
  output logic      scl_w,
  output logic      sda_w
);
  timeunit 1ns;
  timeprecision 10ps;
  logic        m_scl = 1'b1;
  logic        m_sda = 1'b1;
  logic        s_sda = 1'b1;
  int unsigned nrise = 0;
  // pull-ups: any party pulling low wins
  assign scl_w = scl_oe_n & m_scl;
  assign sda_w = sda_oe_n & m_sda & s_sda;
  always @(posedge scl_w) nrise <= nrise + 1;
  always @(sda_w) if (scl_w) nrise <= 0;
  // receiver ack during the ninth clock
  always @(negedge scl_w) s_sda <= !(ack_en && nrise == 8);
  task automatic send_addr(input logic [7:0] b, output logic ack);
    m_sda = 1'b0;
    #62.5 m_scl = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #31.25 m_sda = b[i];
      #31.25 m_scl = 1'b1;
      #62.5 m_scl = 1'b0;
    end
    #31.25 m_sda = 1'b1;
    #31.25 m_scl = 1'b1;
    #31.25 ack = sda_w;
    #31.25 m_scl = 1'b0;
  endtask
  task automatic send_stop();
    #31.25 m_sda = 1'b0;
    #31.25 m_scl = 1'b1;
    wait (scl_w);
    #62.5 m_sda = 1'b1;
    #62.5;
  endtask
endmodule

/* File: testbench/multi_master_i2c_regs_tb.sv */
/*
 * testbench: apb register checks, slave address frames and master bytes.
 * assumes instance 0 wires go to the partner, instance 1 wires only pull up.
 */
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
  miscompares++; $display("BAD %s exp %h got %h", what, exp, got); end end
module multi_master_i2c_regs_tb;
  timeunit 1ns;
  timeprecision 10ps;
  typedef struct packed {
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] ra;
    logic [7:0] rdv;
    logic       err;
  } reg_row_t;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] clk;
    logic [7:0] adr;
    logic [7:0] byt;
    logic       ack;
  } frame_row_t;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ack_en = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, uart_alt_route, scl0, sda0, ack, err;
  logic [1:0]  scl_oe_n, sda_oe_n, if_active;
  logic [8:0]  cap = 9'h000;
  logic [7:0]  rd;
  int          miscompares = 0, comparisons = 0, n;
  reg_row_t    regs [10] = '{
    '{8'h10, 8'h9f, 8'h10, 8'h9f, 1'b0},
    '{8'h30, 8'h5a, 8'h10, 8'h9f, 1'b0},
    '{8'hff, 8'h00, 8'h20, 8'h04, 1'b0},
    '{8'h0c, 8'ha5, 8'h0c, 8'ha5, 1'b0},
    '{8'h14, 8'h37, 8'h14, 8'h37, 1'b0},
    '{8'h04, 8'h3c, 8'h04, 8'h00, 1'b0},
    '{8'h08, 8'h3c, 8'h08, 8'h00, 1'b0},
    '{8'h18, 8'hc0, 8'h18, 8'hd0, 1'b0},
    '{8'h18, 8'h00, 8'h18, 8'h10, 1'b0},
    '{8'h1c, 8'h55, 8'h1c, 8'h00, 1'b1}};
  frame_row_t  frames [8] = '{
    '{8'h08, 8'h80, 8'ha4, 8'ha4, 1'b0},
    '{8'h08, 8'h80, 8'ha4, 8'ha5, 1'b0},
    '{8'h08, 8'h80, 8'ha4, 8'h36, 1'b1},
    '{8'h28, 8'h80, 8'ha5, 8'ha5, 1'b0},
    '{8'h28, 8'h80, 8'ha5, 8'ha4, 1'b1},
    '{8'h18, 8'h80, 8'ha4, 8'h36, 1'b0},
    '{8'h08, 8'h80, 8'ha4, 8'h00, 1'b0},
    '{8'h08, 8'hc0, 8'ha4, 8'ha4, 1'b1}};

  multi_master_i2c_regs dut (
    .clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .scl_i({scl_oe_n[1], scl0}), .sda_i({sda_oe_n[1], sda0}), .scl_o(),
    .scl_oe_n, .sda_o(), .sda_oe_n, .if_active, .uart_alt_route);
  i2c_bus_partner bus (
    .scl_oe_n(scl_oe_n[0]), .sda_oe_n(sda_oe_n[0]), .ack_en, .scl_w(scl0), .sda_w(sda0));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge scl0) cap <= {cap[7:0], sda0};

  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k = 0;
    @(posedge clk_sys);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= {24'h00_0000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd  = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) miscompares++;
  endtask

  task automatic mbyte(input logic [7:0] b, input logic a);
    int k = 0;
    apb(8'h04, 1'b1, b);
    do begin
      apb(8'h18, 1'b0, 8'h00);
      k++;
    end while (rd[4] !== 1'b0 && k < 100);
    `CHK("pin", 1'b0, rd[4])
    `CHK("lrb", a, rd[0])
    `CHK("wire bits", {b, a}, cap)
    apb(8'h04, 1'b0, 8'h00);
    `CHK("shift", b, rd)
  endtask

  task print_verdict();
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    `CHK("oe", 4'hf, {scl_oe_n, sda_oe_n})
    `CHK("active", 2'b00, if_active)
    apb(8'h18, 1'b0, 8'h00);
    `CHK("status", 8'h10, rd)
    apb(8'h00, 1'b1, 8'h01);
    repeat (3) @(posedge clk_sys);
    `CHK("uart alt", 1'b1, uart_alt_route)
    apb(8'h00, 1'b1, 8'h05);
    n = 0;
    while (if_active[0] !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("valid delay", 1'b1, n >= 19 && n <= 23)
    `CHK("uart alt", 1'b0, uart_alt_route)
    apb(8'h20, 1'b1, 8'h05);
    repeat (25) @(posedge clk_sys);
    `CHK("active", 2'b11, if_active)
    foreach (regs[i]) begin
      if (regs[i].wa != 8'hff) apb(regs[i].wa, 1'b1, regs[i].wd);
      apb(regs[i].ra, 1'b0, 8'h00);
      `CHK("reg read", regs[i].rdv, rd)
      `CHK("reg err", regs[i].err, err)
    end
    repeat (20) @(posedge clk_sys);
    foreach (frames[i]) begin
      apb(8'h14, 1'b1, frames[i].ctl);
      apb(8'h10, 1'b1, frames[i].clk);
      apb(8'h0c, 1'b1, frames[i].adr);
      bus.send_addr(frames[i].byt, ack);
      `CHK("ack", frames[i].ack, ack)
      apb(8'h18, 1'b1, 8'h10);
      bus.send_stop();
      apb(8'h0c, 1'b0, 8'h00);
      `CHK("addr", frames[i].adr & 8'hfe, rd)
    end
    ack_en <= 1'b1;
    apb(8'h14, 1'b1, 8'h08);
    apb(8'h10, 1'b1, 8'h80);
    apb(8'h18, 1'b1, 8'hc0);
    mbyte(8'ha5, 1'b0);
    ack_en <= 1'b0;
    mbyte(8'h3c, 1'b1);
    apb(8'h08, 1'b1, 8'h5c);
    repeat (16) @(posedge clk_sys);
    n = 0;
    repeat (40) @(posedge clk_sys) if (scl_oe_n[0] === 1'b0) n++;
    `CHK("scl pulses", 0, n)
    apb(8'h04, 1'b0, 8'h00);
    `CHK("txbuf load", 8'h5c, rd)
    apb(8'h18, 1'b0, 8'h00);
    `CHK("lrb clear", 1'b0, rd[0])
    apb(8'h14, 1'b1, 8'h00);
    repeat (4) @(posedge clk_sys);
    `CHK("released", 2'b11, {scl_oe_n[0], sda_oe_n[0]})
    apb(8'h18, 1'b0, 8'h00);
    `CHK("forced flags", 8'h10, rd & 8'h38)
    apb(8'h04, 1'b1, 8'h77);
    apb(8'h04, 1'b0, 8'h00);
    `CHK("blocked write", 8'h5c, rd)
    print_verdict();
  end
endmodule
